/* hw/icb_core.sv */
// two-wire bus controller core: apb registers, prescaler, master clock
// generator with wired-and synchronisation, shift paths and events.
// assumes open-drain pads outside and one 100 MHz clock for everything.
//
// Operation
// RQ1: module clock tick comes every prescale_value plus one input clocks.
// RQ2: software writes prescale_value only while module_out_of_reset is zero.
// RQ3: prescale_value takes effect when module_out_of_reset rises, later writes ignored.
// RQ4: master clock low and high phases count clk_low_count and clk_high_count ticks.
// RQ5: serial clock is driven only while configured as bus master.
// RQ6: transmit word is copied from tx_data_reg into tx_shifter, then shifted out.
// RQ7: received bits enter rx_shifter, finished word is copied into rx_data_reg.
// RQ8: any falling clock edge restarts this device's own low period.
// RQ9: clock stays low until the longest low period ends.
// RQ10: after its low count, device waits for released clock before high count.
// RQ11: a device holding clock low stretches it; generators wait meanwhile.
// RQ12: software should pick module clock near 7 to 12 MHz.
// RQ13: arbitration against another master is resolved by this device.
// RQ14: data and clock inputs pass a noise filter before use.
// RQ15: interrupts and dma events follow data transmission and reception.
// RQ16: initiator is master and makes the clock; addressed devices are slaves.
// RQ17: both lines are open drain: pull low or release only.
// RQ18: data changes only while clock is low.
// RQ19: prescaler and divider are enable ticks within the input clock domain.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module icb_core #(
  parameter int FILT_CYC = icb_pkg::FILT_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // events
  output logic irq_o,
  output logic dma_tx_evt_o,
  output logic dma_rx_evt_o
);

  typedef struct packed {
    logic oor;
    logic mst;
    logic txm;
    logic [7:0] psc_wr;
    logic [7:0] psc_act;
    logic [7:0] psc_cnt;
    logic [15:0] clk_low;
    logic [15:0] clk_high;
    logic [15:0] cg_cnt;
    icb_pkg::icb_cg_t cg;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic txfull;
    logic active;
    logic [3:0] bitcnt;
    logic arb_lost;
    logic sda_low;
    logic scl_low;
    logic scl_d;
    logic [icb_pkg::STAT_W-1:0] status;
    logic [icb_pkg::STAT_W-1:0] mask;
    logic [31:0] rdata;
    logic slverr;
    logic dtx;
    logic drx;
  } icb_core_state_t;

  icb_core_state_t s_r;
  icb_core_state_t s_nxt;
  logic scl_f;
  logic sda_f;
  logic tick;
  logic fall;
  logic rise;
  logic acc;
  logic wr;
  logic start;
  logic done;
  logic cg_run;
  logic low_end;
  logic high_end;
  logic [7:0] rx_new;
  logic [icb_pkg::STAT_W-1:0] stat_set;
  logic [icb_pkg::STAT_W-1:0] stat_clr;

  // ---------------------------------------------------------------
  // pin filters
  // ---------------------------------------------------------------
  icb_filter #(.FILT_CYC(FILT_CYC)) u_scl_filt (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .pin_i(scl_i),
    .filt_o(scl_f)
  );

  icb_filter #(.FILT_CYC(FILT_CYC)) u_sda_filt (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .pin_i(sda_i),
    .filt_o(sda_f)
  );

  // ---------------------------------------------------------------
  // decode and strobes
  // ---------------------------------------------------------------
  // the module tick is an enable, not a derived clock, so no second domain
  assign tick = s_r.oor && (s_r.psc_cnt == s_r.psc_act); // RQ1 RQ19
  assign fall = s_r.scl_d && !scl_f;
  assign rise = !s_r.scl_d && scl_f;
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign start = wr && (paddr_i == icb_pkg::ADDR_MODE) && pwdata_i[icb_pkg::MODE_GO]
    && s_r.oor && !s_r.active;
  assign done = s_r.active && rise && (s_r.bitcnt == icb_pkg::BIT_LAST);
  assign cg_run = s_r.mst && s_r.oor && !s_r.arb_lost; // RQ5 RQ16
  assign low_end = ({1'b0, s_r.cg_cnt} + 17'h00001) >= {1'b0, s_r.clk_low};
  assign high_end = ({1'b0, s_r.cg_cnt} + 17'h00001) >= {1'b0, s_r.clk_high};
  assign rx_new = {s_r.rxsh[6:0], sda_f};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    stat_set = '0;
    stat_clr = '0;
    s_nxt.dtx = 1'b0;
    s_nxt.drx = 1'b0;
    s_nxt.scl_d = scl_f;
    // setup phase: capture read data so prdata comes from a flop
    if (psel_i && !penable_i)
    begin
      s_nxt.rdata = '0;
      s_nxt.slverr = 1'b0;
      case (paddr_i)
        icb_pkg::ADDR_MODE:
        begin
          s_nxt.rdata[icb_pkg::MODE_OOR] = s_r.oor;
          s_nxt.rdata[icb_pkg::MODE_MST] = s_r.mst;
          s_nxt.rdata[icb_pkg::MODE_TX] = s_r.txm;
        end
        icb_pkg::ADDR_PSC: s_nxt.rdata[7:0] = s_r.psc_wr;
        icb_pkg::ADDR_CLKL: s_nxt.rdata[15:0] = s_r.clk_low;
        icb_pkg::ADDR_CLKH: s_nxt.rdata[15:0] = s_r.clk_high;
        icb_pkg::ADDR_TXD: s_nxt.rdata[7:0] = s_r.txd;
        icb_pkg::ADDR_RXD: s_nxt.rdata[7:0] = s_r.rxd;
        icb_pkg::ADDR_STAT: s_nxt.rdata[icb_pkg::STAT_W-1:0] = s_r.status;
        icb_pkg::ADDR_MASK: s_nxt.rdata[icb_pkg::STAT_W-1:0] = s_r.mask;
        icb_pkg::ADDR_STATE:
        begin
          s_nxt.rdata[icb_pkg::SS_ACTIVE] = s_r.active;
          s_nxt.rdata[icb_pkg::SS_ARB] = s_r.arb_lost;
          s_nxt.rdata[icb_pkg::SS_SCL] = scl_f;
          s_nxt.rdata[icb_pkg::SS_SDA] = sda_f;
          s_nxt.rdata[icb_pkg::SS_TXFULL] = s_r.txfull;
        end
        default: s_nxt.slverr = 1'b1;
      endcase
    end
    // only bits that were actually returned are cleared, so a late event survives
    if (acc && !pwrite_i && (paddr_i == icb_pkg::ADDR_STAT))
    begin
      stat_clr = s_r.rdata[icb_pkg::STAT_W-1:0];
    end
    // access phase writes
    if (wr)
    begin
      case (paddr_i)
        icb_pkg::ADDR_MODE:
        begin
          s_nxt.oor = pwdata_i[icb_pkg::MODE_OOR];
          s_nxt.mst = pwdata_i[icb_pkg::MODE_MST];
          s_nxt.txm = pwdata_i[icb_pkg::MODE_TX];
          // prescale is taken only on the way out of module reset
          if (!s_r.oor && pwdata_i[icb_pkg::MODE_OOR])
          begin
            s_nxt.psc_act = s_r.psc_wr; // RQ3
          end
        end
        icb_pkg::ADDR_PSC: s_nxt.psc_wr = pwdata_i[7:0];
        icb_pkg::ADDR_CLKL: s_nxt.clk_low = pwdata_i[15:0];
        icb_pkg::ADDR_CLKH: s_nxt.clk_high = pwdata_i[15:0];
        icb_pkg::ADDR_TXD:
        begin
          s_nxt.txd = pwdata_i[7:0];
          s_nxt.txfull = 1'b1;
        end
        icb_pkg::ADDR_MASK: s_nxt.mask = pwdata_i[icb_pkg::STAT_W-1:0];
        default: s_nxt.slverr = s_r.slverr;
      endcase
    end
    // prescaler counter
    s_nxt.psc_cnt = (!s_r.oor || tick) ? 8'h00 : s_r.psc_cnt + 8'h01; // RQ1
    // master clock generator
    if (!cg_run)
    begin
      s_nxt.cg = icb_pkg::CG_IDLE;
      s_nxt.scl_low = 1'b0;
      s_nxt.cg_cnt = 16'h0000;
    end
    else
    begin
      case (s_r.cg)
        icb_pkg::CG_IDLE:
        begin
          s_nxt.scl_low = 1'b0;
          // a new word waits for a module tick so that its first low phase is whole
          if (s_r.active && tick)
          begin
            s_nxt.cg = icb_pkg::CG_LOW; // RQ4 RQ5
            s_nxt.cg_cnt = 16'h0000;
            s_nxt.scl_low = 1'b1;
          end
        end
        icb_pkg::CG_LOW:
        begin
          s_nxt.scl_low = 1'b1;
          if (tick)
          begin
            s_nxt.cg_cnt = s_r.cg_cnt + 16'h0001; // RQ4
          end
          // the pulled line must be seen low before letting go of it
          if (tick && low_end && !scl_f)
          begin
            s_nxt.scl_low = 1'b0;
            s_nxt.cg_cnt = 16'h0000;
            s_nxt.cg = s_r.active ? icb_pkg::CG_WAIT : icb_pkg::CG_IDLE;
          end
        end
        icb_pkg::CG_WAIT:
        begin
          // another device may still hold the line low: stretch
          if (scl_f)
          begin
            s_nxt.cg = icb_pkg::CG_HIGH; // RQ9 RQ10 RQ11
            s_nxt.cg_cnt = 16'h0000;
          end
        end
        icb_pkg::CG_HIGH:
        begin
          if (fall || (tick && high_end))
          begin
            s_nxt.cg = icb_pkg::CG_LOW; // RQ8 RQ4
            s_nxt.cg_cnt = 16'h0000;
            s_nxt.scl_low = 1'b1;
          end
          else if (tick)
          begin
            s_nxt.cg_cnt = s_r.cg_cnt + 16'h0001;
          end
        end
        default: s_nxt.cg = icb_pkg::CG_IDLE;
      endcase
    end
    // word start
    if (start)
    begin
      s_nxt.active = 1'b1;
      s_nxt.bitcnt = 4'h0;
      s_nxt.arb_lost = 1'b0;
      if (s_nxt.txm)
      begin
        s_nxt.txsh = s_r.txd; // RQ6
        s_nxt.txfull = 1'b0;
        s_nxt.dtx = 1'b1; // RQ15
        stat_set[icb_pkg::ST_TXE] = 1'b1;
      end
    end
    // shift paths: data moves on the falling edge, is sampled on the rising one
    if (s_r.active)
    begin
      if (fall)
      begin
        s_nxt.sda_low = s_r.txm && !s_r.arb_lost && !s_r.txsh[7]; // RQ6 RQ17 RQ18
      end
      if (rise)
      begin
        s_nxt.rxsh = rx_new; // RQ7
        s_nxt.txsh = {s_r.txsh[6:0], 1'b0};
        s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        // a released one read back as zero means another master won
        if (s_r.txm && s_r.mst && !s_r.sda_low && !sda_f && !s_r.arb_lost)
        begin
          s_nxt.arb_lost = 1'b1; // RQ13
          stat_set[icb_pkg::ST_ARB] = 1'b1;
        end
        if (done)
        begin
          s_nxt.active = 1'b0;
          s_nxt.rxd = rx_new; // RQ7
          stat_set[icb_pkg::ST_DONE] = 1'b1;
          if (!s_r.txm)
          begin
            s_nxt.drx = 1'b1; // RQ15
            stat_set[icb_pkg::ST_RXF] = 1'b1;
          end
        end
      end
    end
    else if (fall)
    begin
      s_nxt.sda_low = 1'b0; // RQ18
    end
    // module reset holds the engine
    if (!s_r.oor)
    begin
      s_nxt.active = 1'b0;
      s_nxt.sda_low = 1'b0;
      s_nxt.arb_lost = 1'b0;
    end
    // set wins over a read clear
    s_nxt.status = (s_r.status & ~stat_clr) | stat_set; // RQ15
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      s_r <= '0;
      s_r.psc_wr <= icb_pkg::PSC_RST;
      s_r.psc_act <= icb_pkg::PSC_RST;
      s_r.clk_low <= icb_pkg::CLKL_RST;
      s_r.clk_high <= icb_pkg::CLKH_RST;
      s_r.cg <= icb_pkg::CG_IDLE;
      s_r.scl_d <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs: open drain, only ever pulled low
  assign scl_o = 1'b0;
  assign scl_oe_o = s_r.scl_low; // RQ5 RQ17
  assign sda_o = 1'b0;
  assign sda_oe_o = s_r.sda_low; // RQ17
  assign prdata_o = s_r.rdata;
  assign pready_o = acc;
  assign pslverr_o = acc && s_r.slverr;
  assign irq_o = |(s_r.status & s_r.mask);
  assign dma_tx_evt_o = s_r.dtx;
  assign dma_rx_evt_o = s_r.drx;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_PSC_HOLD: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ3
    (s_r.oor && s_nxt.oor) |=> $stable(s_r.psc_act))
    else $error("prescale changed while out of reset");
  AST_PSC_LOAD: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ3
    $rose(s_r.oor) |-> (s_r.psc_act == $past(s_r.psc_wr)))
    else $error("prescale not loaded on leaving reset");
  AST_TICK_DIV2: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ1
    (tick && (s_r.psc_act == 8'h01)) |=> !tick ##1 (tick || !s_r.oor))
    else $error("tick spacing wrong for prescale one");
  AST_SCL_MASTER: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ5
    scl_oe_o |-> $past(s_r.mst) || s_r.mst)
    else $error("clock driven while not master");
  AST_WAIT_RELEASE: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ10
    (s_r.cg == icb_pkg::CG_WAIT && !scl_f) |=> (s_r.cg != icb_pkg::CG_HIGH))
    else $error("high count began before line release");
  AST_FALL_RESTART: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ8
    (cg_run && s_r.cg == icb_pkg::CG_HIGH && fall && !start)
    |=> (s_r.cg == icb_pkg::CG_LOW && s_r.cg_cnt == 16'h0000 && scl_oe_o))
    else $error("falling edge did not restart low period");
  AST_SDA_STABLE: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ18
    $changed(s_r.sda_low) |-> !s_r.scl_d)
    else $error("data changed while clock high");
  AST_TX_COPY: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ6
    (start && pwdata_i[icb_pkg::MODE_TX]) |=> (s_r.txsh == $past(s_r.txd)) && dma_tx_evt_o)
    else $error("transmit word not copied");
  AST_RX_COPY: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ7 RQ15
    (done && !s_r.txm && s_r.oor) |=> (s_r.rxd == $past(rx_new)) && dma_rx_evt_o)
    else $error("receive word not copied");
  AST_ARB: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ13
    (!s_r.arb_lost && s_nxt.arb_lost) |=> s_r.status[icb_pkg::ST_ARB] ##1 !scl_oe_o)
    else $error("lost arbitration not handled");

endmodule

/* hw/icb_filter.sv */
// pin noise filter: two-flop synchroniser followed by a stability counter.
// assumes an asynchronous pin input; output idles high like a pulled-up line.
`timescale 1ns/1ps
module icb_filter #(
  parameter int FILT_CYC = icb_pkg::FILT_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic filt_o
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic out;
    logic [7:0] cnt;
  } icb_filt_state_t;

  icb_filt_state_t s_r;
  icb_filt_state_t s_nxt;

  // a new level is taken only once it has stood for FILT_CYC cycles
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync1 = pin_i;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.cnt = 8'h00;
    if (s_r.sync2 != s_r.out)
    begin
      s_nxt.cnt = s_r.cnt + 8'h01;
      if (s_r.cnt + 8'h01 >= 8'(FILT_CYC))
      begin
        s_nxt.out = s_r.sync2; // RQ14
        s_nxt.cnt = 8'h00;
      end
    end
  end

  // state register
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      s_r <= '0;
      s_r.sync1 <= 1'b1;
      s_r.sync2 <= 1'b1;
      s_r.out <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign filt_o = s_r.out;

endmodule

/* hw/icb_pkg.sv */
// package for the two-wire bus controller: register map, field positions,
// reset values, timing counts and the clock generator state type.
// assumes a 32-bit apb slave port and a 100 MHz input clock.
package icb_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_PSC = 8'h04;
  localparam logic [7:0] ADDR_CLKL = 8'h08;
  localparam logic [7:0] ADDR_CLKH = 8'h0c;
  localparam logic [7:0] ADDR_TXD = 8'h10;
  localparam logic [7:0] ADDR_RXD = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1c;
  localparam logic [7:0] ADDR_STATE = 8'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MODE_OOR = 0; // module_out_of_reset
  localparam int MODE_MST = 1; // bus master
  localparam int MODE_TX = 2; // transmitter
  localparam int MODE_GO = 3; // start one word, write only
  localparam int ST_TXE = 0; // tx_data_reg emptied into the shifter
  localparam int ST_RXF = 1; // rx_data_reg filled
  localparam int ST_ARB = 2; // arbitration lost
  localparam int ST_DONE = 3; // word finished
  localparam int STAT_W = 4;
  localparam int SS_ACTIVE = 0;
  localparam int SS_ARB = 1;
  localparam int SS_SCL = 2;
  localparam int SS_SDA = 3;
  localparam int SS_TXFULL = 4;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam logic [15:0] CLKL_RST = 16'h0005;
  localparam logic [15:0] CLKH_RST = 16'h0005;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILT_TIME_NS = 50;
  localparam int FILT_CYC = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // master clock generator states
  typedef enum logic [1:0] {CG_IDLE, CG_LOW, CG_WAIT, CG_HIGH} icb_cg_t;

endpackage

/* tb/icb_partner.sv */
// far-side bus device: a slave that can stretch the clock and send a word.
// assumes pulled-up wired-and lines and the bench's 100 MHz clock.
`timescale 1ns/1ps
module icb_partner (
  // clock
  input wire logic clock_i,
  // line level and our pulls
  input wire logic scl_i,
  output logic scl_pull_o,
  output logic sda_pull_o,
  // bench control
  input wire logic load_i,
  input wire logic [7:0] byte_i,
  input wire logic [7:0] stretch_i
);
  logic scl_q = 1'b1;
  logic [3:0] idx = 4'h0;
  logic [7:0] hold = 8'h00;
  initial
  begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  // on each clock fall: present the next bit and, when stretch_i is nonzero, hold the clock low from the same cycle
  // only pulls low or releases, so the lines stay a wired-and
  always @(posedge clock_i)
  begin
    scl_q <= scl_i;
    if (load_i)
      idx <= 4'h8;
    if (scl_q && !scl_i)
    begin
      hold <= stretch_i;
      sda_pull_o <= (idx != 4'h0) && !byte_i[idx - 4'h1];
      if (idx != 4'h0)
        idx <= idx - 4'h1;
    end
    else if (hold != 8'h00)
      hold <= hold - 8'h01;
    scl_pull_o <= (scl_q && !scl_i && stretch_i != 8'h00) || hold > 8'h01;
  end
endmodule

/* tb/test_icb_core.sv */
// self-checking bench for the bus controller core with one partner slave.
// assumes the core answers apb with zero wait states and a 100 MHz clock.
`timescale 1ns/1ps
module test_icb_core;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic irq_o, dma_tx_evt_o, dma_rx_evt_o;
  logic scl, sda, p_scl, p_sda;
  logic load = 1'b0;
  logic [7:0] pbyte = 8'h00;
  logic [7:0] stretch = 8'h00;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [7:0] seen, byt;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int n_checks = 0;
  int lo_min, lo_max, hi_min, hi_max, t_lo, t_hi, nrise, n_tx, n_rx, bad_sda, psc, cl, ch;
  logic rose;

  always #5 clock_i = ~clock_i;
  // pulled-up wired-and of the core and the partner
  assign scl = !(scl_oe_o | p_scl);
  assign sda = !(sda_oe_o | p_sda);

  icb_core #(.FILT_CYC(3)) icb_core_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .irq_o(irq_o), .dma_tx_evt_o(dma_tx_evt_o),
    .dma_rx_evt_o(dma_rx_evt_o));
  icb_partner icb_partner_i (.clock_i(clock_i), .scl_i(scl), .scl_pull_o(p_scl),
    .sda_pull_o(p_sda), .load_i(load), .byte_i(pbyte), .stretch_i(stretch));

  // ---------------------------------------------------------------
  // line monitor: phase lengths, sampled bits, data changes in high
  // ---------------------------------------------------------------
  always @(posedge clock_i)
  begin
    scl_q <= scl;
    sda_q <= sda;
    n_tx = n_tx + int'(dma_tx_evt_o);
    n_rx = n_rx + int'(dma_rx_evt_o);
    if (scl && scl_q && sda !== sda_q)
      bad_sda = bad_sda + 1;
    if (scl && !scl_q)
    begin
      lo_min = (t_lo < lo_min) ? t_lo : lo_min;
      lo_max = (t_lo > lo_max) ? t_lo : lo_max;
      if (nrise < 8)
        seen = {seen[6:0], sda};
      nrise = nrise + 1;
      rose = 1'b1;
    end
    // idle high before the first rise is not a clock phase
    if (!scl && scl_q && rose)
    begin
      hi_min = (t_hi < hi_min) ? t_hi : hi_min;
      hi_max = (t_hi > hi_max) ? t_hi : hi_max;
    end
    t_lo = scl ? 0 : t_lo + 1;
    t_hi = scl ? t_hi + 1 : 0;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1)
      @(posedge clock_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  // one word: partner loaded, mode set, then started and polled to idle
  task automatic word(input logic [31:0] mode, input logic [7:0] tx, input logic [7:0] pb,
    input logic [7:0] st);
    apb(1'b1, icb_pkg::ADDR_TXD, {24'h0, tx});
    pbyte <= pb;
    stretch <= st;
    load <= 1'b1;
    @(posedge clock_i);
    load <= 1'b0;
    lo_min = 100000;
    hi_min = 100000;
    lo_max = 0;
    hi_max = 0;
    nrise = 0;
    rose = 1'b0;
    bad_sda = 0;
    n_tx = 0;
    n_rx = 0;
    apb(1'b1, icb_pkg::ADDR_MODE, mode);
    apb(1'b1, icb_pkg::ADDR_MODE, mode | (32'h1 << icb_pkg::MODE_GO));
    rd = 32'h1;
    while (rd[icb_pkg::SS_ACTIVE] !== 1'b0)
      apb(1'b0, icb_pkg::ADDR_STATE, 32'h0);
    // the last low phase outlives the word: let the line go idle first
    while (t_hi < 100)
      @(posedge clock_i);
  endtask

  // expected phase length on the wire; filter latency allowed on top
  function automatic logic in_win(input int v, input int t);
    return v >= t && v <= t + 9;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #400000;
    failures++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(33233));
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    apb(1'b0, icb_pkg::ADDR_CLKL, 32'h0);
    check(rd, {16'h0, icb_pkg::CLKL_RST}, "clkl reset");
    apb(1'b0, icb_pkg::ADDR_MODE, 32'h0);
    check(rd, 32'h0, "mode reset");
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    $display("test registers done");
    // random master words: timing, bit order, events, interrupt masking
    for (int i = 0; i < 4; i++)
    begin
      psc = $urandom % 4;
      cl = 10 + $urandom % 8;
      ch = 10 + $urandom % 8;
      byt = 8'($urandom);
      apb(1'b1, icb_pkg::ADDR_MODE, 32'h0);
      apb(1'b1, icb_pkg::ADDR_PSC, 32'(psc));
      apb(1'b1, icb_pkg::ADDR_CLKL, 32'(cl));
      apb(1'b1, icb_pkg::ADDR_CLKH, 32'(ch));
      apb(1'b1, icb_pkg::ADDR_MASK, (i == 0) ? 32'h0 : 32'h8);
      word(32'h7, byt, 8'hff, 8'h00);
      check({24'h0, seen}, {24'h0, byt}, "tx bits");
      check(32'(bad_sda), 32'h0, "data change in high");
      check(32'(n_tx), 32'h1, "tx dma event");
      check(32'(in_win(lo_max, (psc + 1) * cl) && in_win(lo_min, (psc + 1) * cl)), 32'h1, "low");
      check(32'(in_win(hi_max, (psc + 1) * ch) && in_win(hi_min, (psc + 1) * ch)), 32'h1, "high");
      check({31'h0, irq_o}, 32'(i != 0), "irq level");
      apb(1'b0, icb_pkg::ADDR_STAT, 32'h0);
      check({31'h0, rd[icb_pkg::ST_DONE]}, 32'h1, "done status");
      apb(1'b0, icb_pkg::ADDR_STAT, 32'h0);
      check(rd, 32'h0, "status cleared");
      check({31'h0, irq_o}, 32'h0, "irq cleared");
      // a prescale write while running must not change the rate
      apb(1'b1, icb_pkg::ADDR_PSC, 32'(psc + 4));
      word(32'h7, byt, 8'hff, 8'h00);
      check(32'(in_win(lo_max, (psc + 1) * cl)), 32'h1, "prescale held");
      $display("test master tx %0d done", i);
    end
    // master receive while the slave stretches every low phase
    word(32'h3, 8'h00, byt ^ 8'h5a, 8'd120);
    apb(1'b0, icb_pkg::ADDR_RXD, 32'h0);
    check(rd, {24'h0, byt ^ 8'h5a}, "rx word");
    check(32'(n_rx), 32'h1, "rx dma event");
    check(32'(lo_min >= 120 && lo_max <= 130), 32'h1, "stretched low");
    check(32'(in_win(hi_max, (psc + 1) * ch)), 32'h1, "high after release");
    $display("test stretch done");
    // slave mode never drives the clock
    apb(1'b1, icb_pkg::ADDR_MODE, 32'h1);
    apb(1'b1, icb_pkg::ADDR_MODE, 32'h9);
    repeat (200) @(posedge clock_i);
    check({31'h0, scl_oe_o}, 32'h0, "slave clock drive");
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    // another transmitter pulls data low against our ones
    apb(1'b1, icb_pkg::ADDR_TXD, 32'hff);
    pbyte <= 8'h00;
    load <= 1'b1;
    @(posedge clock_i);
    load <= 1'b0;
    // module clock of 10 MHz, set while still in module reset
    apb(1'b1, icb_pkg::ADDR_PSC, 32'h9);
    apb(1'b1, icb_pkg::ADDR_MODE, 32'h7);
    apb(1'b1, icb_pkg::ADDR_MODE, 32'hf);
    repeat (300) @(posedge clock_i);
    apb(1'b0, icb_pkg::ADDR_STAT, 32'h0);
    check({31'h0, rd[icb_pkg::ST_ARB]}, 32'h1, "arbitration lost");
    check({31'h0, scl_oe_o | sda_oe_o}, 32'h0, "drive dropped");
    check({31'h0, scl_o | sda_o}, 32'h0, "pins only pull low");
    $display("test arbitration done");
    report_and_stop();
  end
endmodule
